// File: fault_status_consts.vh
/*
 * Constants of the fault status block: command codes, bit positions,
 * reset and preset values, and fixed error-queue answers.
 * Assumes inclusion by its bare name from the design files of this block.
 */
`ifndef FAULT_STATUS_CONSTS_VH
`define FAULT_STATUS_CONSTS_VH

// Command codes on the command port.
`define OP_READ_CONDITION 4'h0
`define OP_READ_EVENT 4'h1
`define OP_WRITE_MASK 4'h2
`define OP_READ_MASK 4'h3
`define OP_WRITE_FALLING 4'h4
`define OP_READ_FALLING 4'h5
`define OP_WRITE_RISING 4'h6
`define OP_READ_RISING 4'h7
`define OP_ERROR_QUEUE_READ 4'h8
`define OP_VERSION_QUERY 4'h9
`define OP_STATUS_PRESET 4'hA

// Condition bit positions.
`define BIT_OVERVOLTAGE 0
`define BIT_OVERCURRENT 1
`define BIT_OVERTEMPERATURE 4
`define BIT_REMOTE_INHIBIT 9
`define BIT_UNREGULATED 10

// Defined condition positions, weights 1, 2, 16, 512 and 1024.
`define DEFINED_BITS 16'h0613
// Rising filter value after a status preset (1555).
`define PRESET_RISING 16'h0613

// Reset values of the writable registers.
`define RESET_MASK 16'h0000
`define RESET_FALLING 16'h0000
`define RESET_RISING 16'h0000

// Status byte summary position.
`define SUMMARY_BIT 3

// Error queue answers.
`define CODE_NO_ERROR 16'h0000
`define MSG_NO_ERROR 8'h00
`define CODE_TOO_MANY 16'hFEA2
`define MSG_TOO_MANY 8'h01

`endif

// File: transition_filter.v
/*
 * Per-bit transition filter: turns condition changes into one-cycle set
 * pulses for the event latch, under rising and falling filter masks.
 * Assumes condition levels synchronous to mclk.
 */
`timescale 1ns/1ns
module transition_filter #(
    parameter W = 16
) (
    input wire mclk,            // system clock
    input wire rst,             // synchronous reset, active high
    input wire [W-1:0] cond,    // live condition levels
    input wire [W-1:0] rise_en, // rising filter mask
    input wire [W-1:0] fall_en, // falling filter mask
    output wire [W-1:0] set_ev  // event set pulses
);
    // Tracking the filtered terms rather than the raw level means a filter
    // bit newly written against a standing level also counts as an edge.
    wire [W-1:0] rise_term;
    wire [W-1:0] fall_term;
    reg [W-1:0] rise_term_r;
    reg [W-1:0] fall_term_r;

    assign rise_term = cond & rise_en;
    assign fall_term = ~cond & fall_en;
    // Both masks set pass either edge, both clear pass none.
    assign set_ev = (rise_term & ~rise_term_r) | (fall_term & ~fall_term_r);

    always @(posedge mclk) begin
        if (rst) begin
            rise_term_r <= {W{1'b0}};
            fall_term_r <= {W{1'b0}};
        end else begin
            rise_term_r <= rise_term;
            fall_term_r <= fall_term;
        end
    end
endmodule

// File: error_queue_mem.v
/*
 * Small memory for the error queue: one write port, one read port whose
 * data come out of a register one edge after the address.
 * Assumes a single clock; reads are read-first on an address collision.
 */
`timescale 1ns/1ns
module error_queue_mem #(
    parameter AW = 3,
    parameter DW = 24
) (
    input wire mclk,            // system clock
    input wire rst,             // synchronous reset, active high
    input wire wr_en,           // write strobe
    input wire [AW-1:0] wr_addr, // write address
    input wire [DW-1:0] wr_data, // write data
    input wire [AW-1:0] rd_addr, // read address
    output reg [DW-1:0] rd_data  // registered read data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            rd_data <= {DW{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// File: fault_status_block.v
/*
 * Questionable fault status group with error queue and version query.
 * Live fault flags form the condition word, filtered edges latch into a
 * clear-on-read event word, and a mask folds events into a summary bit.
 * Assumes all inputs synchronous to mclk and one command per cycle at most.
 */
`timescale 1ns/1ns
`include "fault_status_consts.vh"

module fault_status_block #(
    parameter ERR_AW = 3,                 // error queue holds 2**ERR_AW entries
    parameter [15:0] VERSION_YEAR = 16'h07D0, // arbitrary year value
    parameter [7:0] VERSION_REV = 8'h00   // arbitrary revision digit
) (
    input wire mclk,                      // system clock, 10 MHz
    input wire rst,                       // synchronous reset, active high
    input wire overvoltage_tripped,       // overvoltage protection tripped
    input wire overcurrent_tripped,       // overcurrent protection tripped
    input wire overtemperature_flag,      // overtemperature present
    input wire remote_inhibit_flag,       // remote inhibit active
    input wire output_unregulated_flag,   // output unregulated
    input wire error_push,                // one-cycle strobe: log an error
    input wire [15:0] error_code,         // signed error number to log
    input wire [7:0] error_msg,           // message string index to log
    input wire cmd_valid,                 // command strobe
    input wire [3:0] cmd_op,              // command code
    input wire [15:0] cmd_data,           // write value
    output reg rsp_valid,                 // one-cycle answer strobe
    output reg [15:0] rsp_data,           // answer value or error number
    output reg [7:0] rsp_aux,             // message index or revision digit
    output reg [7:0] status_byte,         // status byte, summary at bit 3
    output reg [ERR_AW:0] error_count,    // entries waiting in the queue
    output reg error_overflow             // queue has overflowed since empty
);
    localparam DEPTH = 1 << ERR_AW;

    wire [15:0] condition;
    wire [15:0] set_ev;
    wire [23:0] mem_rd_data;

    reg [15:0] event_r;
    reg [15:0] event_nxt;
    reg [15:0] mask_r;
    reg [15:0] mask_nxt;
    reg [15:0] falling_r;
    reg [15:0] falling_nxt;
    reg [15:0] rising_r;
    reg [15:0] rising_nxt;

    reg [ERR_AW-1:0] wr_ptr_r;
    reg [ERR_AW-1:0] wr_ptr_nxt;
    reg [ERR_AW-1:0] rd_ptr_r;
    reg [ERR_AW-1:0] rd_ptr_nxt;
    reg [ERR_AW:0] count_r;
    reg [ERR_AW:0] count_nxt;
    reg overflow_nxt;
    reg mem_wr_en;
    reg [ERR_AW-1:0] mem_wr_addr;
    reg [23:0] mem_wr_data;

    reg stage_valid_r;
    reg stage_from_mem_r;
    reg [15:0] stage_data_r;
    reg [7:0] stage_aux_r;
    reg stage_valid_nxt;
    reg stage_from_mem_nxt;
    reg [15:0] stage_data_nxt;
    reg [7:0] stage_aux_nxt;

    wire is_read_event;
    wire is_queue_read;
    wire queue_empty;
    wire queue_full;
    wire pop;
    wire is_write_mask;
    wire is_write_falling;
    wire is_write_rising;
    wire is_preset;
    reg [7:0] status_nxt;

    function is_op;
        input valid;
        input [3:0] op;
        input [3:0] code;
        begin
            is_op = valid && (op == code);
        end
    endfunction

    // Unused positions are cut wherever a word enters the filter or event path.
    function [15:0] keep_defined;
        input [15:0] value;
        begin
            keep_defined = value & `DEFINED_BITS;
        end
    endfunction

    function [ERR_AW-1:0] ptr_inc;
        input [ERR_AW-1:0] ptr;
        begin
            ptr_inc = ptr + {{(ERR_AW-1){1'b0}}, 1'b1};
        end
    endfunction

    function [ERR_AW-1:0] ptr_dec;
        input [ERR_AW-1:0] ptr;
        begin
            ptr_dec = ptr - {{(ERR_AW-1){1'b0}}, 1'b1};
        end
    endfunction

    function [ERR_AW:0] count_inc;
        input [ERR_AW:0] cnt;
        begin
            count_inc = cnt + {{ERR_AW{1'b0}}, 1'b1};
        end
    endfunction

    function [ERR_AW:0] count_dec;
        input [ERR_AW:0] cnt;
        begin
            count_dec = cnt - {{ERR_AW{1'b0}}, 1'b1};
        end
    endfunction

    // Live flags; unlisted positions are tied low.
    assign condition = {5'h00,
                        output_unregulated_flag,
                        remote_inhibit_flag,
                        4'h0,
                        overtemperature_flag,
                        2'h0,
                        overcurrent_tripped,
                        overvoltage_tripped};

    transition_filter #(
        .W(16)
    ) u_filter (
        .mclk(mclk),
        .rst(rst),
        .cond(condition),
        .rise_en(rising_r),
        .fall_en(falling_r),
        .set_ev(set_ev)
    );

    error_queue_mem #(
        .AW(ERR_AW),
        .DW(24)
    ) u_queue (
        .mclk(mclk),
        .rst(rst),
        .wr_en(mem_wr_en),
        .wr_addr(mem_wr_addr),
        .wr_data(mem_wr_data),
        .rd_addr(rd_ptr_r),
        .rd_data(mem_rd_data)
    );

    assign is_read_event = is_op(cmd_valid, cmd_op, `OP_READ_EVENT);
    assign is_queue_read = is_op(cmd_valid, cmd_op, `OP_ERROR_QUEUE_READ);
    assign queue_empty = (count_r == {(ERR_AW+1){1'b0}});
    assign queue_full = (count_r == DEPTH[ERR_AW:0]);
    assign pop = is_queue_read && !queue_empty;
    assign is_write_mask = is_op(cmd_valid, cmd_op, `OP_WRITE_MASK);
    assign is_write_falling = is_op(cmd_valid, cmd_op, `OP_WRITE_FALLING);
    assign is_write_rising = is_op(cmd_valid, cmd_op, `OP_WRITE_RISING);
    assign is_preset = is_op(cmd_valid, cmd_op, `OP_STATUS_PRESET);

    // A filter event in the same cycle as the clearing read survives.
    always @* begin
        event_nxt = is_read_event ? 16'h0000 : event_r;
        event_nxt = keep_defined(event_nxt | set_ev);
    end

    always @* begin
        mask_nxt = mask_r;
        falling_nxt = falling_r;
        rising_nxt = rising_r;
        if (is_write_mask) begin
            mask_nxt = cmd_data;
        end
        // Undefined filter positions are dropped so they read back as zero.
        if (is_write_falling) begin
            falling_nxt = keep_defined(cmd_data);
        end
        if (is_write_rising) begin
            rising_nxt = keep_defined(cmd_data);
        end
        if (is_preset) begin
            mask_nxt = 16'h0000;
            falling_nxt = 16'h0000;
            rising_nxt = `PRESET_RISING;
        end
    end

    // The summary uses the next event and mask words, so a mask write or a
    // clearing read shows in the status byte at the same edge.
    always @* begin
        status_nxt = 8'h00;
        status_nxt[`SUMMARY_BIT] = |(event_nxt & mask_nxt);
    end

    // Error queue pointers. When full with no pop, a new error does not advance anything;
    // it overwrites the newest slot with the too-many code so the oldest errors are kept.
    always @* begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        overflow_nxt = error_overflow;
        mem_wr_en = 1'b0;
        mem_wr_addr = wr_ptr_r;
        mem_wr_data = {error_msg, error_code};
        if (pop) begin
            rd_ptr_nxt = ptr_inc(rd_ptr_r);
        end
        if (error_push) begin
            if (!queue_full || pop) begin
                mem_wr_en = 1'b1;
                wr_ptr_nxt = ptr_inc(wr_ptr_r);
            end else begin
                mem_wr_en = 1'b1;
                mem_wr_addr = ptr_dec(wr_ptr_r);
                mem_wr_data = {`MSG_TOO_MANY, `CODE_TOO_MANY};
                overflow_nxt = 1'b1;
            end
        end
        if (error_push && !pop && !queue_full) begin
            count_nxt = count_inc(count_r);
        end else if (pop && !error_push) begin
            count_nxt = count_dec(count_r);
        end
        if (count_nxt == {(ERR_AW+1){1'b0}}) begin
            overflow_nxt = 1'b0;
        end
    end

    // First answer stage: picks the value seen in the command cycle.
    always @* begin
        stage_valid_nxt = 1'b0;
        stage_from_mem_nxt = 1'b0;
        stage_data_nxt = 16'h0000;
        stage_aux_nxt = 8'h00;
        if (cmd_valid) begin
            case (cmd_op)
                `OP_READ_CONDITION: begin
                    stage_valid_nxt = 1'b1;
                    stage_data_nxt = condition;
                end
                `OP_READ_EVENT: begin
                    stage_valid_nxt = 1'b1;
                    stage_data_nxt = event_r;
                end
                `OP_READ_MASK: begin
                    stage_valid_nxt = 1'b1;
                    stage_data_nxt = mask_r;
                end
                `OP_READ_FALLING: begin
                    stage_valid_nxt = 1'b1;
                    stage_data_nxt = falling_r;
                end
                `OP_READ_RISING: begin
                    stage_valid_nxt = 1'b1;
                    stage_data_nxt = rising_r;
                end
                `OP_ERROR_QUEUE_READ: begin
                    stage_valid_nxt = 1'b1;
                    stage_from_mem_nxt = !queue_empty;
                    stage_data_nxt = `CODE_NO_ERROR;
                    stage_aux_nxt = `MSG_NO_ERROR;
                end
                `OP_VERSION_QUERY: begin
                    stage_valid_nxt = 1'b1;
                    stage_data_nxt = VERSION_YEAR;
                    stage_aux_nxt = VERSION_REV;
                end
                default: begin
                    stage_valid_nxt = 1'b0;
                end
            endcase
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            event_r <= 16'h0000;
            mask_r <= `RESET_MASK;
            falling_r <= `RESET_FALLING;
            rising_r <= `RESET_RISING;
            wr_ptr_r <= {ERR_AW{1'b0}};
            rd_ptr_r <= {ERR_AW{1'b0}};
            count_r <= {(ERR_AW+1){1'b0}};
            error_overflow <= 1'b0;
            error_count <= {(ERR_AW+1){1'b0}};
            status_byte <= 8'h00;
        end else begin
            event_r <= event_nxt;
            mask_r <= mask_nxt;
            falling_r <= falling_nxt;
            rising_r <= rising_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            error_overflow <= overflow_nxt;
            error_count <= count_nxt;
            status_byte <= status_nxt;
        end
    end

    // The memory answers one edge after its address, so every query is
    // answered two edges after the command to keep one fixed latency.
    always @(posedge mclk) begin
        if (rst) begin
            stage_valid_r <= 1'b0;
            stage_from_mem_r <= 1'b0;
            stage_data_r <= 16'h0000;
            stage_aux_r <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
            rsp_aux <= 8'h00;
        end else begin
            stage_valid_r <= stage_valid_nxt;
            stage_from_mem_r <= stage_from_mem_nxt;
            stage_data_r <= stage_data_nxt;
            stage_aux_r <= stage_aux_nxt;
            rsp_valid <= stage_valid_r;
            if (stage_from_mem_r) begin
                rsp_data <= mem_rd_data[15:0];
                rsp_aux <= mem_rd_data[23:16];
            end else begin
                rsp_data <= stage_data_r;
                rsp_aux <= stage_aux_r;
            end
        end
    end
endmodule

// File: fault_status_sva.sv
/* Port checker for the fault status block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module fault_status_sva #(
    parameter ERR_AW = 3,
    parameter [15:0] VERSION_YEAR = 16'h0000,
    parameter [7:0] VERSION_REV = 8'h00
) (
    input wire mclk, // clock
    input wire rst, // reset
    input wire overvoltage_tripped, // fault flag
    input wire overcurrent_tripped, // fault flag
    input wire overtemperature_flag, // fault flag
    input wire remote_inhibit_flag, // fault flag
    input wire output_unregulated_flag, // fault flag
    input wire error_push, // log strobe
    input wire cmd_valid, // command strobe
    input wire [3:0] cmd_op, // command code
    input wire [15:0] cmd_data, // write value
    input wire rsp_valid, // answer strobe
    input wire [15:0] rsp_data, // answer value
    input wire [7:0] rsp_aux, // answer side field
    input wire [7:0] status_byte, // status byte
    input wire [ERR_AW:0] error_count, // queue fill
    input wire error_overflow // overflow mark
);
    localparam int DEPTH = 1 << ERR_AW;
    wire [15:0] cw = {5'h00, output_unregulated_flag, remote_inhibit_flag, 4'h0,
        overtemperature_flag, 2'h0, overcurrent_tripped, overvoltage_tripped};
    wire isq = cmd_valid && (cmd_op inside {4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9});
    wire pop = cmd_valid && cmd_op == 4'h8;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_answer_two: assert property (isq |-> ##2 rsp_valid)
        else $error("query not answered");
    a_no_stray: assert property (rsp_valid |-> $past(isq, 2))
        else $error("answer without query");
    a_cond_live: assert property (cmd_valid && cmd_op == 4'h0 |-> ##2 rsp_data == $past(cw, 2))
        else $error("condition word wrong");
    a_version_fixed: assert property (cmd_valid && cmd_op == 4'h9 |-> ##2
        rsp_data == VERSION_YEAR && rsp_aux == VERSION_REV) else $error("version wrong");
    a_byte_unused: assert property (status_byte[7:4] == 4'h0 && status_byte[2:0] == 3'h0)
        else $error("status byte spare bit set");
    a_mask_zero: assert property (cmd_valid && cmd_op == 4'h2 && cmd_data == 16'h0000
        |=> !status_byte[3]) else $error("summary with empty mask");
    a_preset_quiet: assert property (cmd_valid && cmd_op == 4'hA |=> !status_byte[3])
        else $error("summary after preset");
    a_empty_zero: assert property (pop && error_count == 0 && !error_push |-> ##2
        rsp_data == 16'h0000 && rsp_aux == 8'h00) else $error("empty queue answer");
    a_pop_one: assert property (pop && error_count != 0 && !error_push
        |=> error_count == $past(error_count) - 1'b1) else $error("pop count");
    a_push_one: assert property (error_push && !pop && error_count < DEPTH
        |=> error_count == $past(error_count) + 1'b1) else $error("push count");
    a_full_mark: assert property (error_push && !pop && error_count == DEPTH
        |=> error_overflow && $stable(error_count)) else $error("overflow mark");
    cover property (pop && error_overflow);
    cover property (rsp_valid && rsp_data == 16'hFEA2);
    cover property ($rose(status_byte[3]));
endmodule

// File: ctrl_model.sv
/* Controller model: sends commands on the strobe port and collects answers.
   Assumes answers arrive within a few cycles of the taking edge. */
`timescale 1ns/1ns
module ctrl_model (
    input wire mclk, // clock
    output reg cmd_valid, // command strobe
    output reg [3:0] cmd_op, // command code
    output reg [15:0] cmd_data, // write value
    input wire rsp_valid, // answer strobe
    input wire [15:0] rsp_data, // answer value
    input wire [7:0] rsp_aux // answer side field
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 4'h0;
        cmd_data = 16'h0000;
    end
    // Idle payload is inverted so a stale value is never mistaken for a live one.
    task send(input [3:0] op, input [15:0] dat);
        begin
            @(negedge mclk);
            cmd_valid = 1'b1;
            cmd_op = op;
            cmd_data = dat;
            @(negedge mclk);
            cmd_valid = 1'b0;
            cmd_op = ~op;
            cmd_data = ~dat;
        end
    endtask
    task ask(input [3:0] op, output ok, output [15:0] dat, output [7:0] aux);
        integer i;
        begin
            send(op, 16'h0000);
            ok = 1'b0;
            for (i = 0; i < 4 && !ok; i = i + 1) begin
                if (rsp_valid === 1'b1) begin
                    ok = 1'b1;
                    dat = rsp_data;
                    aux = rsp_aux;
                end else begin
                    @(negedge mclk);
                end
            end
        end
    endtask
endmodule

// File: tb.sv
/* Self-checking bench: fault levels, filters, mask, error queue, version.
   Assumes the block, its checker and the controller model are compiled. */
`timescale 1ns/1ns
module tb;
    localparam [15:0] YEAR = 16'h07E3; // arbitrary value
    localparam [7:0] REV = 8'h04; // arbitrary value
    reg mclk, rst, error_push, ok;
    reg [4:0] fl, f;
    reg [15:0] error_code, d, m;
    reg [7:0] error_msg, a;
    reg [23:0] e;
    reg [23:0] q [0:8];
    reg [31:0] seed;
    wire cmd_valid, rsp_valid, error_overflow;
    wire [3:0] cmd_op, error_count;
    wire [15:0] cmd_data, rsp_data;
    wire [7:0] rsp_aux, status_byte;
    integer err_count, n_checks, k;
    fault_status_block #(.ERR_AW(3), .VERSION_YEAR(YEAR), .VERSION_REV(REV))
    u_fault_status_block (.mclk(mclk), .rst(rst), .overvoltage_tripped(fl[0]),
        .overcurrent_tripped(fl[1]), .overtemperature_flag(fl[2]),
        .remote_inhibit_flag(fl[3]), .output_unregulated_flag(fl[4]),
        .error_push(error_push), .error_code(error_code), .error_msg(error_msg),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_aux(rsp_aux),
        .status_byte(status_byte), .error_count(error_count),
        .error_overflow(error_overflow));
    ctrl_model u_ctrl_model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_aux(rsp_aux));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [15:0] cw(input [4:0] v);
        cw = {5'h00, v[4], v[3], 4'h0, v[2], 2'h0, v[1], v[0]};
    endfunction
    task test_done;
        begin
            $display("checks %0d errors %0d", n_checks, err_count);
            if (err_count == 0 && n_checks > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // A missing answer ends the run, since later expectations would be meaningless.
    task rd(input [3:0] op, input [15:0] exp);
        begin
            u_ctrl_model.ask(op, ok, d, a);
            chk({15'h0000, ok}, 16'h0001);
            if (ok !== 1'b1) test_done;
            chk(d, exp);
        end
    endtask
    task push(input [23:0] v);
        begin
            @(negedge mclk);
            error_push = 1'b1;
            {error_msg, error_code} = v;
            @(negedge mclk);
            error_push = 1'b0;
            {error_msg, error_code} = ~v;
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        error_push = 1'b0;
        fl = 5'h00;
        error_code = 16'h0000;
        error_msg = 8'h00;
        err_count = 0;
        n_checks = 0;
        seed = 32'h00000062;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        rd(4'h3, 16'h0000);
        rd(4'h5, 16'h0000);
        rd(4'h7, 16'h0000);
        rd(4'h9, YEAR);
        chk({8'h00, a}, {8'h00, REV});
        for (k = 0; k < 8; k = k + 1) begin
            seed = xs(seed);
            @(negedge mclk) fl = seed[4:0];
            rd(4'h0, cw(seed[4:0]));
        end
        rd(4'h1, 16'h0000);
        u_ctrl_model.ask(4'hF, ok, d, a);
        chk({15'h0000, ok}, 16'h0000);
        for (k = 0; k < 4; k = k + 1) begin
            seed = xs(seed);
            m = (k == 0) ? 16'h7FD7 : seed[15:0] % 16'h7FD8;
            u_ctrl_model.send(4'h2, m);
            u_ctrl_model.send(4'h4, m);
            u_ctrl_model.send(4'h6, m >> 1);
            rd(4'h3, m);
            rd(4'h5, m & 16'h0613);
            rd(4'h7, (m >> 1) & 16'h0613);
        end
        u_ctrl_model.send(4'hA, 16'h0000);
        rd(4'h3, 16'h0000);
        rd(4'h5, 16'h0000);
        rd(4'h7, 16'h0613);
        @(negedge mclk) fl = 5'h00;
        u_ctrl_model.ask(4'h1, ok, d, a);
        f = seed[12:8] | 5'h01;
        @(negedge mclk) fl = f;
        rd(4'h1, cw(f));
        rd(4'h1, 16'h0000);
        u_ctrl_model.send(4'h6, 16'h0000);
        u_ctrl_model.send(4'h4, 16'h0613);
        rd(4'h1, cw(~f));
        @(negedge mclk) fl = 5'h00;
        rd(4'h1, cw(f));
        u_ctrl_model.send(4'h6, 16'h0613);
        for (k = 0; k < 6; k = k + 1) begin
            seed = xs(seed);
            f = seed[4:0] | 5'h01;
            @(negedge mclk) fl = f;
            m = (k == 0) ? 16'h0000 : seed[20:5] & 16'h7FD7;
            u_ctrl_model.send(4'h2, m);
            chk({15'h0000, status_byte[3]}, {15'h0000, |(m & cw(f))});
            rd(4'h1, cw(f));
            chk({15'h0000, status_byte[3]}, 16'h0000);
            @(negedge mclk) fl = 5'h00;
            rd(4'h1, cw(f));
        end
        for (k = 0; k < 9; k = k + 1) begin
            seed = xs(seed);
            q[k] = seed[23:0];
            push(q[k]);
        end
        chk({12'h000, error_count}, 16'h0008);
        chk({15'h0000, error_overflow}, 16'h0001);
        for (k = 0; k < 9; k = k + 1) begin
            e = (k < 7) ? q[k] : (k == 7) ? 24'h01FEA2 : 24'h000000;
            rd(4'h8, e[15:0]);
            chk({8'h00, a}, {8'h00, e[23:16]});
        end
        chk({15'h0000, error_overflow}, 16'h0000);
        push(24'h0155AA);
        chk({12'h000, error_count}, 16'h0001);
        // A second reset in mid-run must bring every register back to its default.
        @(negedge mclk) rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        chk({12'h000, error_count}, 16'h0000);
        rd(4'h8, 16'h0000);
        chk({8'h00, a}, 16'h0000);
        rd(4'h3, 16'h0000);
        rd(4'h5, 16'h0000);
        rd(4'h7, 16'h0000);
        rd(4'h1, 16'h0000);
        test_done;
    end
endmodule
bind fault_status_block fault_status_sva #(.ERR_AW(ERR_AW), .VERSION_YEAR(VERSION_YEAR),
    .VERSION_REV(VERSION_REV)) u_fault_status_sva (.mclk(mclk), .rst(rst),
    .overvoltage_tripped(overvoltage_tripped), .overcurrent_tripped(overcurrent_tripped),
    .overtemperature_flag(overtemperature_flag), .remote_inhibit_flag(remote_inhibit_flag),
    .output_unregulated_flag(output_unregulated_flag), .error_push(error_push),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_aux(rsp_aux), .status_byte(status_byte),
    .error_count(error_count), .error_overflow(error_overflow));
